// ===== inc/rsc_pkg.sv
// Purpose: constants for the reset source controller
// Assumes: 200 MHz system clock
// Notes: register map and timing constants
package rsc_pkg;
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned POR_MIN_NS = 150;
	localparam int unsigned POR_MIN_CYC = (POR_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [7:0] POR_CNT_RESET = 8'h00;
	localparam int unsigned TRIP_STEP_MV = 250;
	localparam int unsigned TRIP_BASE_MV = 1700;
	localparam int unsigned HIGH_TRIP_MV = 5750;
	localparam int unsigned TRIP_MAX_CODE = 15;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_SWRST = 4'h1;
	localparam logic [3:0] ADDR_LVCFG = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam logic [3:0] ADDR_WDT = 4'h4;
	localparam logic [3:0] ADDR_BUZZ = 4'h5;
	localparam logic [3:0] ADDR_LEVEL = 4'h6;
	localparam int unsigned CTRL_SWDIS = 0;
	localparam int unsigned CTRL_AREG_EN = 1;
	localparam int unsigned CTRL_DPRES_EN = 2;
	localparam int unsigned CTRL_SLEEP = 3;
	localparam int unsigned CTRL_HIBER = 4;
	localparam int unsigned CTRL_BOOT_DONE = 5;
	localparam int unsigned ST_POR = 0;
	localparam int unsigned ST_PRECISE_LOW_VOLTAGE_RESET = 1;
	localparam int unsigned ST_EXTERNAL_RESET_PIN = 2;
	localparam int unsigned ST_WDT = 3;
	localparam int unsigned ST_SW = 4;
	localparam int unsigned ST_ALV = 5;
	localparam int unsigned ST_DLV = 6;
	localparam int unsigned ST_AHV = 7;
	localparam logic [7:0] CTRL_RESET = 8'h06;
	localparam logic [15:0] LVCFG_RESET = 16'h0000;
	localparam logic [15:0] WDT_RESET = 16'hffff;
	localparam logic [15:0] BUZZ_RESET = 16'h0100;
	localparam logic [3:0] BUZZ_ON_CYC = 4'h8;
	localparam int unsigned SYNC_STAGES = 2;
endpackage

// ===== rtl/rsc_sync.sv
// Purpose: two-stage synchroniser for one level
// Assumes: asynchronous active-low reset
// Notes: first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module rsc_sync (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic rst_val_i,
	input wire logic d_i,
	output logic q_o
);
	logic meta_r;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_r <= 1'b0;
			q_o <= 1'b0;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
	logic unused_w;
	assign unused_w = rst_val_i;
endmodule
`default_nettype wire

// ===== rtl/rsc_top.sv
// Purpose: gathers all reset sources into one system reset
// Assumes: 200 MHz clock, monitor comparators outside, pins asynchronous
// Notes: status cleared only by power-on reset
// Overview of operation
// - out-of-range supply raises reset, all modes; here none in hibernate or unbuzzed sleep, and high trip never resets
// - monitors interrupt before reaching reset thresholds
// - unserviced watchdog window produces reset
// - software request bit write starts reset
// - status records causes, cleared by power-on
// - system reset reaches core and peripherals
// - power-on pulse minimum width, stretched by ramps
// - after boot power-on monitor hands to precise
// - precise trip acts like power-on reset
// - software cannot disable digital precise monitor
// - analog regulator off disables analog precise
// - precise monitor off in sleep, buzzed
// - low trips stepped, high trip fixed
// - low monitors may reset instead of interrupt
// - interrupt monitors disabled until power-on done
// - buzz interrupt waits for wakeup first
// - external pin low holds reset
// - external pin works in sleep, hibernate
// - software reset same as power-on
// - disable bit blocks software reset
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module rsc_top (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic por_ramp_i,
	input wire logic precise_low_voltage_reset_dig_trip_i,
	input wire logic precise_low_voltage_reset_ana_trip_i,
	input wire logic alv_trip_i,
	input wire logic dlv_trip_i,
	input wire logic ahv_trip_i,
	input wire logic external_reset_pin_n_i,
	input wire logic wdt_kick_i,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	output logic sys_reset_n_o,
	output logic monitor_irq_o,
	output logic wake_req_o,
	output logic precise_low_voltage_reset_dig_en_o,
	output logic precise_low_voltage_reset_ana_en_o,
	output logic lv_mon_en_o,
	output logic buzz_o,
	output logic [3:0] alv_trip_code_o,
	output logic [3:0] dlv_trip_code_o
);
	// power-on domain: reset_n_i is the power-on source itself
	logic [7:0] por_cnt_r;
	logic por_done_r;
	logic ramp_s, pd_s, pa_s, alv_s, dlv_s, ahv_s, external_reset_pin_s;
	logic [7:0] ctrl_r;
	logic [15:0] lvcfg_r;
	logic [15:0] wdt_lim_r, wdt_cnt_r, buzz_per_r, buzz_cnt_r;
	logic [3:0] buzz_on_r;
	logic wdt_en_r;
	logic [7:0] status_r, status_nxt;
	logic sw_req_r, wdt_fire_r;
	logic buzzing_w, sleeping_w, precise_low_voltage_reset_dig_act_w, precise_low_voltage_reset_ana_act_w;
	logic precise_low_voltage_reset_trip_w, lv_reset_w, any_src_w;
	logic rst_a_r, rst_b_r;
	logic irq_pend_r;

	rsc_sync u_ramp (.clk_i(clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b0),
		.d_i(por_ramp_i), .q_o(ramp_s));
	rsc_sync u_pd (.clk_i(clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b0),
		.d_i(precise_low_voltage_reset_dig_trip_i), .q_o(pd_s));
	rsc_sync u_pa (.clk_i(clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b0),
		.d_i(precise_low_voltage_reset_ana_trip_i), .q_o(pa_s));
	rsc_sync u_alv (.clk_i(clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b0),
		.d_i(alv_trip_i), .q_o(alv_s));
	rsc_sync u_dlv (.clk_i(clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b0),
		.d_i(dlv_trip_i), .q_o(dlv_s));
	rsc_sync u_ahv (.clk_i(clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b0),
		.d_i(ahv_trip_i), .q_o(ahv_s));
	rsc_sync u_xr (.clk_i(clk_i), .reset_n_i(reset_n_i), .rst_val_i(1'b0),
		.d_i(~external_reset_pin_n_i), .q_o(external_reset_pin_s));

	// power-on pulse, at least the minimum width, stretched while ramping
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			por_cnt_r <= rsc_pkg::POR_CNT_RESET;
			por_done_r <= 1'b0;
		end else if (ramp_s) begin
			por_cnt_r <= rsc_pkg::POR_CNT_RESET;
			por_done_r <= 1'b0;
		end else if (por_cnt_r < 8'(rsc_pkg::POR_MIN_CYC)) begin
			por_cnt_r <= por_cnt_r + 8'h01;
		end else begin
			por_done_r <= 1'b1;
		end
	end

	assign sleeping_w = ctrl_r[rsc_pkg::CTRL_SLEEP] | ctrl_r[rsc_pkg::CTRL_HIBER];
	assign buzzing_w = ctrl_r[rsc_pkg::CTRL_SLEEP] && !ctrl_r[rsc_pkg::CTRL_HIBER]
		&& (buzz_on_r != 4'h0);
	// digital precise stays on in normal mode once the boot-done bit is set, regardless of software
	assign precise_low_voltage_reset_dig_act_w = ctrl_r[rsc_pkg::CTRL_BOOT_DONE]
		&& (!sleeping_w || buzzing_w);
	assign precise_low_voltage_reset_ana_act_w = precise_low_voltage_reset_dig_act_w && ctrl_r[rsc_pkg::CTRL_AREG_EN];
	assign precise_low_voltage_reset_trip_w = (precise_low_voltage_reset_dig_act_w && pd_s) || (precise_low_voltage_reset_ana_act_w && pa_s);
	assign lv_reset_w = por_done_r && (!sleeping_w || buzzing_w)
		&& ((lvcfg_r[8] && alv_s) || (lvcfg_r[9] && dlv_s));
	assign any_src_w = !por_done_r || precise_low_voltage_reset_trip_w || external_reset_pin_s || wdt_fire_r
		|| sw_req_r || lv_reset_w;

	// power-on asserts async, other sources on the next edge; two-flop release
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_a_r <= 1'b0;
			rst_b_r <= 1'b0;
		end else if (any_src_w) begin
			rst_a_r <= 1'b0;
			rst_b_r <= 1'b0;
		end else begin
			rst_a_r <= 1'b1;
			rst_b_r <= rst_a_r;
		end
	end
	assign sys_reset_n_o = rst_b_r;

	// control registers, returned to defaults by any system reset; the boot-done bit is kept except at power-on, which clears it
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_r <= rsc_pkg::CTRL_RESET;
			lvcfg_r <= rsc_pkg::LVCFG_RESET;
			wdt_lim_r <= rsc_pkg::WDT_RESET;
			buzz_per_r <= rsc_pkg::BUZZ_RESET;
		end else if (!rst_b_r) begin
			ctrl_r <= rsc_pkg::CTRL_RESET | {2'b00, ctrl_r[rsc_pkg::CTRL_BOOT_DONE], 5'b00000};
			lvcfg_r <= rsc_pkg::LVCFG_RESET;
			wdt_lim_r <= rsc_pkg::WDT_RESET;
			buzz_per_r <= rsc_pkg::BUZZ_RESET;
		end else if (wr_i) begin
			case (addr_i)
				rsc_pkg::ADDR_CTRL: begin
					ctrl_r <= {wdata_i[7:3] | {2'b00, ctrl_r[rsc_pkg::CTRL_BOOT_DONE], 2'b00},
						1'b1, wdata_i[1:0]};
				end
				rsc_pkg::ADDR_LVCFG: begin
					lvcfg_r <= {6'h00, wdata_i[9:0]};
				end
				rsc_pkg::ADDR_WDT: begin
					wdt_lim_r <= wdata_i;
				end
				rsc_pkg::ADDR_BUZZ: begin
					buzz_per_r <= wdata_i;
				end
				default: begin
				end
			endcase
		end
	end
	assign alv_trip_code_o = lvcfg_r[3:0];
	assign dlv_trip_code_o = lvcfg_r[7:4];

	// software reset request, blocked by disable bit
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sw_req_r <= 1'b0;
		end else begin
			sw_req_r <= wr_i && (addr_i == rsc_pkg::ADDR_SWRST) && wdata_i[0]
				&& !ctrl_r[rsc_pkg::CTRL_SWDIS] && rst_b_r;
		end
	end

	// watchdog: enabled by any write to the limit register,
	// cleared only by power-on; kick restarts window
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wdt_en_r <= 1'b0;
			wdt_cnt_r <= 16'h0000;
			wdt_fire_r <= 1'b0;
		end else begin
			if (wr_i && addr_i == rsc_pkg::ADDR_WDT && rst_b_r) begin
				wdt_en_r <= 1'b1;
			end
			if (!rst_b_r || wdt_kick_i || !wdt_en_r) begin
				wdt_cnt_r <= 16'h0000;
				wdt_fire_r <= 1'b0;
			end else if (wdt_cnt_r >= wdt_lim_r) begin
				wdt_fire_r <= 1'b1;
			end else begin
				wdt_cnt_r <= wdt_cnt_r + 16'h0001;
			end
		end
	end

	// buzz timer in sleep
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			buzz_cnt_r <= 16'h0000;
			buzz_on_r <= 4'h0;
		end else if (!ctrl_r[rsc_pkg::CTRL_SLEEP]) begin
			buzz_cnt_r <= 16'h0000;
			buzz_on_r <= 4'h0;
		end else if (buzz_on_r != 4'h0) begin
			buzz_on_r <= buzz_on_r - 4'h1;
		end else if (buzz_cnt_r >= buzz_per_r) begin
			buzz_cnt_r <= 16'h0000;
			buzz_on_r <= rsc_pkg::BUZZ_ON_CYC;
		end else begin
			buzz_cnt_r <= buzz_cnt_r + 16'h0001;
		end
	end

	// status: set wins; only power-on clears
	always_comb begin
		status_nxt = status_r;
		if (!por_done_r) status_nxt[rsc_pkg::ST_POR] = 1'b1;
		if (precise_low_voltage_reset_trip_w) status_nxt[rsc_pkg::ST_PRECISE_LOW_VOLTAGE_RESET] = 1'b1;
		if (external_reset_pin_s) status_nxt[rsc_pkg::ST_EXTERNAL_RESET_PIN] = 1'b1;
		if (wdt_fire_r) status_nxt[rsc_pkg::ST_WDT] = 1'b1;
		if (sw_req_r) status_nxt[rsc_pkg::ST_SW] = 1'b1;
		if (lv_mon_en_o && alv_s) status_nxt[rsc_pkg::ST_ALV] = 1'b1;
		if (lv_mon_en_o && dlv_s) status_nxt[rsc_pkg::ST_DLV] = 1'b1;
		if (lv_mon_en_o && ahv_s) status_nxt[rsc_pkg::ST_AHV] = 1'b1;
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_r <= 8'h00;
		end else begin
			status_r <= status_nxt;
		end
	end

	// monitor interrupt; in sleep raise wake first, irq after wakeup
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_pend_r <= 1'b0;
			wake_req_o <= 1'b0;
			monitor_irq_o <= 1'b0;
		end else if (!rst_b_r) begin
			irq_pend_r <= 1'b0;
			wake_req_o <= 1'b0;
			monitor_irq_o <= 1'b0;
		end else begin
			if (lv_mon_en_o && ((alv_s && !lvcfg_r[8]) || (dlv_s && !lvcfg_r[9])
				|| (ahv_s && lvcfg_r[10 - 1 + 0]))) begin
				irq_pend_r <= 1'b1;
			end
			wake_req_o <= irq_pend_r && sleeping_w;
			monitor_irq_o <= irq_pend_r && !sleeping_w;
			if (monitor_irq_o) begin
				irq_pend_r <= 1'b0;
			end
		end
	end

	// outputs from flops
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			precise_low_voltage_reset_dig_en_o <= 1'b0;
			precise_low_voltage_reset_ana_en_o <= 1'b0;
			lv_mon_en_o <= 1'b0;
			buzz_o <= 1'b0;
		end else begin
			precise_low_voltage_reset_dig_en_o <= precise_low_voltage_reset_dig_act_w;
			precise_low_voltage_reset_ana_en_o <= precise_low_voltage_reset_ana_act_w;
			lv_mon_en_o <= por_done_r && (!sleeping_w || buzzing_w);
			buzz_o <= buzzing_w;
		end
	end

	// register read, one cycle later
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			case (addr_i)
				rsc_pkg::ADDR_CTRL: rdata_o <= {8'h00, ctrl_r};
				rsc_pkg::ADDR_LVCFG: rdata_o <= lvcfg_r;
				rsc_pkg::ADDR_STATUS: rdata_o <= {8'h00, status_r};
				rsc_pkg::ADDR_WDT: rdata_o <= wdt_lim_r;
				rsc_pkg::ADDR_BUZZ: rdata_o <= buzz_per_r;
				rsc_pkg::ADDR_LEVEL: rdata_o <= {9'h000, ahv_s, dlv_s, alv_s, external_reset_pin_s,
					pa_s, pd_s, por_done_r};
				default: rdata_o <= 16'h0000;
			endcase
		end else begin
			rdata_o <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

// ===== bench/rsc_pin_model.sv
// Purpose: external reset pin driver with pull-up
// Assumes: press_i from bench, same clock
// Notes: re-press honoured only after the release gap
`timescale 1ns/100ps
`default_nettype none
module rsc_pin_model #(parameter int GAP_CYC = 2000) (
	input wire logic clk_i,
	input wire logic press_i,
	output logic pin_n_o
);
	int gap_cnt_r = GAP_CYC;
	logic low_r = 1'b0;
	// pull-up: released pin reads high
	assign pin_n_o = !low_r;
	always @(posedge clk_i) begin
		low_r <= press_i && (low_r || gap_cnt_r >= GAP_CYC);
		gap_cnt_r <= low_r ? 0 : (gap_cnt_r < GAP_CYC ? gap_cnt_r + 1 : gap_cnt_r);
	end
endmodule
`default_nettype wire

// ===== bench/rsc_properties.sv
// Purpose: port checks for the reset controller
// Assumes: one clock domain
// Notes: bound to rsc_top below
`timescale 1ns/100ps
`default_nettype none
module rsc_props (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic por_ramp_i,
	input wire logic precise_low_voltage_reset_dig_trip_i,
	input wire logic precise_low_voltage_reset_ana_trip_i,
	input wire logic external_reset_pin_n_i,
	input wire logic [3:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic sys_reset_n_o,
	input wire logic monitor_irq_o,
	input wire logic precise_low_voltage_reset_dig_en_o,
	input wire logic precise_low_voltage_reset_ana_en_o,
	input wire logic [3:0] alv_trip_code_o
);
	logic [7:0] por_cnt_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// cycles since supplies stopped ramping
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			por_cnt_r <= 8'h00;
		end else if (por_ramp_i) begin
			por_cnt_r <= 8'h00;
		end else if (por_cnt_r != 8'hff) begin
			por_cnt_r <= por_cnt_r + 8'h01;
		end
	end
	pin_hold_a: assert property (!external_reset_pin_n_i |-> ##[0:3] !sys_reset_n_o)
		else $error("pin low without system reset");
	precise_low_voltage_reset_dig_a: assert property (precise_low_voltage_reset_dig_trip_i && precise_low_voltage_reset_dig_en_o |-> ##[0:3] !sys_reset_n_o)
		else $error("digital precise trip missed");
	precise_low_voltage_reset_ana_a: assert property (precise_low_voltage_reset_ana_trip_i && precise_low_voltage_reset_ana_en_o |-> ##[0:3] !sys_reset_n_o)
		else $error("analog precise trip missed");
	clean_release_a: assert property ($rose(sys_reset_n_o) |-> $past(external_reset_pin_n_i, 2))
		else $error("release while pin low");
	por_width_a: assert property (por_cnt_r < 8'd30 |-> !sys_reset_n_o)
		else $error("power-on pulse too short");
	irq_gate_a: assert property (!sys_reset_n_o && !$past(sys_reset_n_o) |-> !monitor_irq_o)
		else $error("interrupt during reset");
	trip_code_a: assert property ($changed(alv_trip_code_o) |->
		$past(wr_i && addr_i == rsc_pkg::ADDR_LVCFG) || !$past(sys_reset_n_o))
		else $error("trip code changed without write");
	read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
		else $error("read data outside read cycle");
	cover property ($fell(sys_reset_n_o));
	cover property ($rose(sys_reset_n_o));
	cover property (monitor_irq_o);
endmodule
bind rsc_top rsc_props chk_u (.clk_i, .reset_n_i, .por_ramp_i, .precise_low_voltage_reset_dig_trip_i, .precise_low_voltage_reset_ana_trip_i,
	.external_reset_pin_n_i, .addr_i, .wr_i, .rd_i, .rdata_o, .sys_reset_n_o, .monitor_irq_o,
	.precise_low_voltage_reset_dig_en_o, .precise_low_voltage_reset_ana_en_o, .alv_trip_code_o);
`default_nettype wire

// ===== bench/rsc_top_tb_top.sv
// Purpose: self-checking bench for the reset controller
// Assumes: 200 MHz clock
// Notes: watchdog scenario runs last, it stays armed
`timescale 1ns/100ps
`default_nettype none
module rsc_top_tb_top;
	logic clk_i, reset_n_i, por_ramp_i, precise_low_voltage_reset_dig_trip_i, precise_low_voltage_reset_ana_trip_i, alv_trip_i;
	logic dlv_trip_i, ahv_trip_i, external_reset_pin_n_i, wdt_kick_i, wr_i, rd_i, press;
	logic [3:0] addr_i, alv_trip_code_o, dlv_trip_code_o;
	logic [15:0] wdata_i, rdata_o, d;
	logic sys_reset_n_o, monitor_irq_o, wake_req_o, precise_low_voltage_reset_dig_en_o, precise_low_voltage_reset_ana_en_o;
	logic lv_mon_en_o, buzz_o;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	int n;
	rsc_top dut_u (.clk_i, .reset_n_i, .por_ramp_i, .precise_low_voltage_reset_dig_trip_i, .precise_low_voltage_reset_ana_trip_i,
		.alv_trip_i, .dlv_trip_i, .ahv_trip_i, .external_reset_pin_n_i, .wdt_kick_i, .addr_i,
		.wdata_i, .wr_i, .rd_i, .rdata_o, .sys_reset_n_o, .monitor_irq_o, .wake_req_o,
		.precise_low_voltage_reset_dig_en_o, .precise_low_voltage_reset_ana_en_o, .lv_mon_en_o, .buzz_o, .alv_trip_code_o, .dlv_trip_code_o);
	rsc_pin_model #(.GAP_CYC(200)) pin_u (.clk_i, .press_i(press), .pin_n_o(external_reset_pin_n_i));
	task automatic end_sim;
		$display("tests_run %0d err_total %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [3:0] a);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
		@(posedge clk_i);
	endtask
	// picks system reset (0), interrupt (1), buzz (2) or wake request (3)
	function automatic logic pick(input logic [1:0] sel);
		case (sel)
			2'd0: pick = sys_reset_n_o;
			2'd1: pick = monitor_irq_o;
			2'd2: pick = buzz_o;
			default: pick = wake_req_o;
		endcase
	endfunction
	// wait for the picked output to reach lvl
	task automatic wait_on(input logic [1:0] sel, input logic lvl, input int lim);
		logic v;
		n = 0;
		#1 v = pick(sel);
		while (v !== lvl && n < lim) begin
			@(posedge clk_i);
			#1 v = pick(sel);
			n++;
		end
		check(16'(v), 16'(lvl));
		@(posedge clk_i);
	endtask
	task automatic status_bit(input int b);
		rd(rsc_pkg::ADDR_STATUS);
		check(16'(d[b]), 16'h0001);
	endtask
	task automatic t_sw;
		wr(rsc_pkg::ADDR_SWRST, 16'h0001);
		wait_on(0, 1'b0, 10);
		wait_on(0, 1'b1, 600);
		status_bit(rsc_pkg::ST_SW);
		wr(rsc_pkg::ADDR_CTRL, 16'h0007);
		wr(rsc_pkg::ADDR_SWRST, 16'h0001);
		repeat (8) @(posedge clk_i);
		check(16'(sys_reset_n_o), 16'h0001);
	endtask
	task automatic t_pin;
		press <= 1'b1;
		wait_on(0, 1'b0, 10);
		repeat (40) @(posedge clk_i);
		check(16'(sys_reset_n_o), 16'h0000);
		press <= 1'b0;
		wait_on(0, 1'b1, 600);
		status_bit(rsc_pkg::ST_EXTERNAL_RESET_PIN);
		status_bit(rsc_pkg::ST_SW);
	endtask
	task automatic t_precise_low_voltage_reset;
		wr(rsc_pkg::ADDR_CTRL, 16'h0026);
		#1 check(16'(precise_low_voltage_reset_dig_en_o), 16'h0001);
		@(posedge clk_i);
		precise_low_voltage_reset_dig_trip_i <= 1'b1;
		wait_on(0, 1'b0, 10);
		precise_low_voltage_reset_dig_trip_i <= 1'b0;
		wait_on(0, 1'b1, 600);
		status_bit(rsc_pkg::ST_PRECISE_LOW_VOLTAGE_RESET);
	endtask
	task automatic t_lv;
		wr(rsc_pkg::ADDR_LVCFG, 16'h0053);
		check({8'h00, dlv_trip_code_o, alv_trip_code_o}, 16'h0053);
		alv_trip_i <= 1'b1;
		wait_on(1, 1'b1, 20);
		check(16'(sys_reset_n_o), 16'h0001);
		alv_trip_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		wr(rsc_pkg::ADDR_LVCFG, 16'h0100);
		#1 check(16'(sys_reset_n_o), 16'h0001);
		@(posedge clk_i);
		alv_trip_i <= 1'b1;
		wait_on(0, 1'b0, 20);
		alv_trip_i <= 1'b0;
		wait_on(0, 1'b1, 600);
		status_bit(rsc_pkg::ST_ALV);
		rd(4'hf);
		check(d, 16'h0000);
	endtask
	task automatic t_sleep;
		wr(rsc_pkg::ADDR_BUZZ, 16'h0020);
		wr(rsc_pkg::ADDR_CTRL, 16'h002e);
		#1 check(16'(lv_mon_en_o), 16'h0000);
		wait_on(2, 1'b1, 100);
		#1 check(16'(precise_low_voltage_reset_dig_en_o), 16'h0001);
		check(16'(lv_mon_en_o), 16'h0001);
		@(posedge clk_i);
		alv_trip_i <= 1'b1;
		wait_on(3, 1'b1, 200);
		#1 check(16'(monitor_irq_o), 16'h0000);
		@(posedge clk_i);
		wr(rsc_pkg::ADDR_CTRL, 16'h0026);
		wait_on(1, 1'b1, 20);
		alv_trip_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic t_wdt;
		wr(rsc_pkg::ADDR_WDT, 16'h0040);
		repeat (4) begin
			repeat (40) @(posedge clk_i);
			wdt_kick_i <= 1'b1;
			@(posedge clk_i);
			wdt_kick_i <= 1'b0;
		end
		check(16'(sys_reset_n_o), 16'h0001);
		wait_on(0, 1'b0, 100);
		wait_on(0, 1'b1, 600);
		status_bit(rsc_pkg::ST_WDT);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = !clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			end_sim();
		end
	end
	initial begin
		{reset_n_i, precise_low_voltage_reset_dig_trip_i, precise_low_voltage_reset_ana_trip_i, alv_trip_i, dlv_trip_i} = '0;
		{ahv_trip_i, wdt_kick_i, wr_i, rd_i, press, addr_i, wdata_i} = '0;
		por_ramp_i = 1'b1;
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		por_ramp_i <= 1'b0;
		wait_on(0, 1'b1, 200);
		check(16'(n >= 30), 16'h0001);
		status_bit(rsc_pkg::ST_POR);
		t_sw();
		t_pin();
		t_precise_low_voltage_reset();
		t_lv();
		t_sleep();
		t_wdt();
		end_sim();
	end
endmodule
`default_nettype wire
